//--- dv/hmr_output_router_monitor.sv
// Port-level assertions for the output router.
`timescale 1ns/1ps
`default_nettype none
module hmr_output_router_monitor
    import hmr_pkg::*;
(
    // Clock, reset and inputs
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       headphoneOrMutePin,
    input wire hmr_cfg_t   cfg,
    input wire logic       pwmCh1,
    input wire logic       pwmCh2,
    input wire logic       pwmMuteSquare,
    input wire logic [3:0] powerPwmIn,
    // Outputs
    input wire logic       logicPwmOutA,
    input wire logic       logicPwmOutAOe,
    input wire logic       logicPwmOutB,
    input wire logic       logicPwmOutBOe,
    input wire logic [3:0] powerPwmOutputs,
    input wire logic       auxiliarySerialOut,
    input wire hmr_dsp_t   dspSettings,
    input wire logic       modulatorMute,
    input wire logic       headphoneActive
);
    logic [2:0] pSync;
    logic [2:0] up;
    logic       sqP, ch1P, ch2P;
    logic [3:0] pwrP;
    hmr_cfg_t   c1;
    // Pin reaches the outputs three edges late
    wire        act = pSync[2] == c1.pinActiveLevel;
    wire        hp  = c1.pinFunctionSelect;
    wire        mo  = c1.logicOutputMapSelect != MAP_OFF;
    wire        ok  = up == 3'h4;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) up <= 3'h0;
        else if (!ok) up <= up + 3'h1;
    end
    always_ff @(posedge clk) begin
        pSync <= {pSync[1:0], headphoneOrMutePin};
        {c1, sqP, ch1P, ch2P, pwrP} <= {cfg, pwmMuteSquare, pwmCh1, pwmCh2, powerPwmIn};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_hp_out_a: assert property (ok && hp && act && mo |-> logicPwmOutA == ch1P)
        else $error("output A not channel 1");
    a_hp_out_b: assert property (ok && hp && act && mo |-> logicPwmOutB == ch2P)
        else $error("output B not channel 2");
    a_power_mute: assert property (ok && act |-> powerPwmOutputs == {4{sqP}})
        else $error("power outputs not muted");
    a_hp_bypass: assert property (ok && hp && act |-> dspSettings.leftMixerSelect == 2'h0
        && !dspSettings.twoWayCrossoverEnable && dspSettings.subCrossoverSelect == BASS_OFF)
        else $error("processing not bypassed");
    a_right_mix: assert property (ok |-> dspSettings.rightMixerSelect == c1.rightMixerSelect)
        else $error("right mixer altered");
    a_idle_mute: assert property (ok && hp && !act && mo |-> logicPwmOutA == sqP
        && logicPwmOutB == sqP && powerPwmOutputs == pwrP) else $error("idle headphone wrong");
    a_pin_flags: assert property (ok |-> modulatorMute == (!hp && act)
        && headphoneActive == (hp && act)) else $error("pin decode wrong");
    a_aux_mute: assert property (ok && !hp && act |-> !auxiliarySerialOut)
        else $error("aux out not muted");
    a_map_off: assert property (ok && !mo |-> !logicPwmOutA && !logicPwmOutB)
        else $error("disabled map not low");
    a_oe_follow: assert property ({logicPwmOutAOe, logicPwmOutBOe}
        == {2{cfg.logicOutputDriveEnable}}) else $error("enable wrong");
    c_hp_on: cover property (ok && hp && act && mo);
    c_mute_on: cover property (ok && !hp && act);
    c_hp_idle: cover property (ok && hp && !act && mo);
endmodule : hmr_output_router_monitor
bind hmr_output_router hmr_output_router_monitor mon (.*);
`default_nettype wire

//--- dv/hmr_output_router_tb_top.sv
// Self-checking bench for the output router.
`timescale 1ns/1ps
`default_nettype none
module hmr_output_router_tb_top;
    import hmr_pkg::*;
    logic       clk = 1'h0, reset_n = 1'h0, want = 1'h0;
    logic       pin, sq, aux, a, ao, b, bo, mm, ha, hp, act, mu, on, eA, eB;
    logic [1:0] m;
    logic [7:0] eD;
    logic [3:0] pw;
    logic [7:0] cnt = 8'h0;
    hmr_cfg_t   cfg = '0;
    hmr_dsp_t   dsp;
    int         errors = 0;
    int         checks_done = 0;
    always #4 clk = !clk;
    always @(negedge clk) cnt <= cnt + 8'h1;
    hmr_pin_source src (.clk(clk), .wantActive(want), .activeLevel(cfg.pinActiveLevel),
        .pin(pin), .muteSquare(sq));
    hmr_output_router uut (.clk(clk), .reset_n(reset_n), .headphoneOrMutePin(pin), .cfg(cfg),
        .pwmCh1(cnt[1]), .pwmCh2(cnt[2]), .pwmSub(cnt[3]), .pwmMuteSquare(sq),
        .powerPwmIn(cnt[7:4]), .auxSerialIn(cnt[1] ^ cnt[3]), .logicPwmOutA(a),
        .logicPwmOutAOe(ao), .logicPwmOutB(b), .logicPwmOutBOe(bo), .powerPwmOutputs(pw),
        .auxiliarySerialOut(aux), .dspSettings(dsp), .modulatorMute(mm), .headphoneActive(ha));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'h1;
        for (int i = 0; i < 256; i++) begin
            @(negedge clk);
            {cfg.logicOutputDriveEnable, cfg.pinFunctionSelect, cfg.pinActiveLevel, want,
                cfg.logicOutputMapSelect} <= i[5:0];
            {cfg.leftMixerSelect, cfg.twoWayCrossoverEnable, cfg.subCrossoverSelect,
                cfg.rightMixerSelect} <= {i[7:6], i[7], i[6], 1'h0, i[6], ~i[1:0]};
            repeat (5) @(posedge clk);
            for (int k = 0; k < 4; k++) begin
                @(posedge clk);
                #2;
                hp  = cfg.pinFunctionSelect;
                m   = cfg.logicOutputMapSelect;
                act = (pin == cfg.pinActiveLevel);
                {mu, on} = {hp ^ act, hp && act};
                eA = (m == MAP_OFF) ? 1'h0 : mu ? sq : (!on && m == MAP_CH2_SUB) ? cnt[2]
                    : cnt[1];
                eB = (m == MAP_OFF) ? 1'h0 : mu ? sq : (on || m == MAP_CH1_CH2) ? cnt[2]
                    : (cfg.subCrossoverSelect == BASS_OFF) ? sq : cnt[3];
                eD = on ? {2'h0, cfg.rightMixerSelect, 4'h0} : {cfg.leftMixerSelect,
                    cfg.rightMixerSelect, cfg.twoWayCrossoverEnable, cfg.subCrossoverSelect};
                chk("outA", eA, a);
                chk("outB", eB, b);
                chk("power", act ? {4{sq}} : cnt[7:4], pw);
                chk("oe", {2{cfg.logicOutputDriveEnable}}, {ao, bo});
                chk("flags", {on, !hp && act}, {ha, mm});
                chk("aux", (!hp && act) ? 1'h0 : cnt[1] ^ cnt[3], aux);
                chk("dsp", eD, dsp);
            end
        end
        tally_and_finish();
    end
    // Hang guard
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule : hmr_output_router_tb_top
`default_nettype wire

//--- dv/hmr_pin_source.sv
// Model of the external headphone detect / mute source.
`timescale 1ns/1ps
`default_nettype none
module hmr_pin_source (
    // Clock and request
    input  wire logic clk,
    input  wire logic wantActive,
    input  wire logic activeLevel,
    // Pin and mute square
    output logic      pin = 1'h0,
    output logic      muteSquare = 1'h0
);
    // Unrelated to the sampling edge, so move on the falling one
    always @(negedge clk) begin
        pin        <= wantActive ? activeLevel : !activeLevel;
        muteSquare <= !muteSquare;
    end
endmodule : hmr_pin_source
`default_nettype wire

//--- rtl/hmr_output_router.sv
// Headphone detect / hardware mute pin interpretation and PWM output routing.
`timescale 1ns/1ps
`default_nettype none

module hmr_output_router
    import hmr_pkg::*;
#(
    parameter int SYNC_DEPTH = SYNC_STAGES
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           reset_n,
    // External pin
    input  wire logic           headphoneOrMutePin,
    // Configuration
    input  wire hmr_pkg::hmr_cfg_t cfg,
    // PWM streams from the modulators
    input  wire logic           pwmCh1,
    input  wire logic           pwmCh2,
    input  wire logic           pwmSub,
    input  wire logic           pwmMuteSquare,
    input  wire logic [3:0]     powerPwmIn,
    input  wire logic           auxSerialIn,
    // Logic-level PWM outputs (three-signal form)
    output logic                logicPwmOutA,
    output logic                logicPwmOutAOe,
    output logic                logicPwmOutB,
    output logic                logicPwmOutBOe,
    // Power PWM outputs and auxiliary serial out
    output logic [3:0]          powerPwmOutputs,
    output logic                auxiliarySerialOut,
    // Effective processing settings
    output hmr_pkg::hmr_dsp_t   dspSettings,
    // Status
    output logic                modulatorMute,
    output logic                headphoneActive
);
    import hmr_pkg::*;

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    // Resets to 0, so a low active level reads as active until the stages refill
    logic [SYNC_DEPTH-1:0] pinSync_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinSync_r <= '0;
        end else begin
            pinSync_r <= {pinSync_r[SYNC_DEPTH-2:0], headphoneOrMutePin};
        end
    end

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    // One compare serves both pin functions, so polarity holds in every mode
    wire pinActive = (pinSync_r[SYNC_DEPTH-1] == cfg.pinActiveLevel);
    wire hpMode    = (cfg.pinFunctionSelect == FUNC_HEADPHONE);
    wire muteNow   = !hpMode && pinActive;
    wire hpNow     = hpMode && pinActive;
    wire hpIdle    = hpMode && !pinActive;
    wire bassOn    = (cfg.subCrossoverSelect != BASS_OFF);

    // Sub mutes without bass management only; headphone bypass routes channel 2 to output B instead
    wire subSig    = bassOn ? pwmSub : pwmMuteSquare;

    // ----------------------------------------
    // Source pick
    // ----------------------------------------
    // Unused source codes fall back to low rather than to stale data
    function automatic logic pickSrc(input hmr_src_t s);
        case (s)
            HMR_SRC_LOW:  pickSrc = 1'b0;
            HMR_SRC_CH1:  pickSrc = pwmCh1;
            HMR_SRC_CH2:  pickSrc = pwmCh2;
            HMR_SRC_SUB:  pickSrc = subSig;
            HMR_SRC_MUTE: pickSrc = pwmMuteSquare;
            default:      pickSrc = 1'b0;
        endcase
    endfunction : pickSrc

    // ----------------------------------------
    // Source selection for logic-level outputs
    // ----------------------------------------
    hmr_src_t srcA;
    hmr_src_t srcB;

    always_comb begin
        srcA = HMR_SRC_LOW;
        srcB = HMR_SRC_LOW;
        case (cfg.logicOutputMapSelect)
            MAP_OFF: begin
                srcA = HMR_SRC_LOW;
                srcB = HMR_SRC_LOW;
            end
            MAP_CH1_CH2: begin
                srcA = HMR_SRC_CH1;
                srcB = HMR_SRC_CH2;
            end
            MAP_CH1_SUB: begin
                srcA = HMR_SRC_CH1;
                srcB = HMR_SRC_SUB;
            end
            MAP_CH2_SUB: begin
                srcA = HMR_SRC_CH2;
                srcB = HMR_SRC_SUB;
            end
            default: begin
                srcA = HMR_SRC_LOW;
                srcB = HMR_SRC_LOW;
            end
        endcase
        // Disabled map stays driven low in every pin state
        if (cfg.logicOutputMapSelect != MAP_OFF) begin
            if (muteNow || hpIdle) begin
                srcA = HMR_SRC_MUTE;
                srcB = HMR_SRC_MUTE;
            end else if (hpNow) begin
                srcA = HMR_SRC_CH1;
                srcB = HMR_SRC_CH2;
            end
        end
    end

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    // Power pins get the square, not silence, so the bridges stay centred
    wire       outA     = pickSrc(srcA);
    wire       outB     = pickSrc(srcB);
    wire       powerMute = muteNow || hpNow;
    wire [3:0] powerNxt = powerMute ? {4{pwmMuteSquare}} : powerPwmIn;

    // ----------------------------------------
    // Processing overrides
    // ----------------------------------------
    hmr_dsp_t dspNxt;
    always_comb begin
        dspNxt.rightMixerSelect      = cfg.rightMixerSelect;
        dspNxt.leftMixerSelect       = hpNow ? 2'h0 : cfg.leftMixerSelect;
        dspNxt.twoWayCrossoverEnable = hpNow ? MIX_OVERRIDE_RESET
                                             : cfg.twoWayCrossoverEnable;
        dspNxt.subCrossoverSelect    = hpNow ? BASS_OFF : cfg.subCrossoverSelect;
    end

    // ----------------------------------------
    // Logic-level output registers
    // ----------------------------------------
    // Registered so a map change cannot glitch an external amplifier input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            logicPwmOutA <= 1'b0;
            logicPwmOutB <= 1'b0;
        end else begin
            logicPwmOutA <= outA;
            logicPwmOutB <= outB;
        end
    end

    // ----------------------------------------
    // Output enables
    // ----------------------------------------
    // Enables follow the bit at once; the data registers are not gated by it
    assign logicPwmOutAOe = cfg.logicOutputDriveEnable;
    assign logicPwmOutBOe = cfg.logicOutputDriveEnable;

    // ----------------------------------------
    // Power and auxiliary output registers
    // ----------------------------------------
    // Muted serial data idles low, not at the last bit sent
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            powerPwmOutputs    <= 4'h0;
            auxiliarySerialOut <= 1'b0;
        end else begin
            powerPwmOutputs    <= powerNxt;
            auxiliarySerialOut <= muteNow ? 1'b0 : auxSerialIn;
        end
    end

    // ----------------------------------------
    // Effective processing settings
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dspSettings <= '0;
        end else begin
            dspSettings <= dspNxt;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Flags lag the pin by the synchroniser depth plus one edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modulatorMute   <= 1'b0;
            headphoneActive <= 1'b0;
        end else begin
            modulatorMute   <= muteNow;
            headphoneActive <= hpNow;
        end
    end

endmodule : hmr_output_router

`default_nettype wire

//--- rtl/hmr_pkg.sv
// Package for the headphone / hardware mute output router.
package hmr_pkg;

    // ----------------------------------------
    // Pin function and mapping encodings
    // ----------------------------------------
    localparam logic       FUNC_MUTE      = 1'b0;
    localparam logic       FUNC_HEADPHONE = 1'b1;
    localparam logic [1:0] MAP_OFF        = 2'h0;
    localparam logic [1:0] MAP_CH1_CH2    = 2'h1;
    localparam logic [1:0] MAP_CH1_SUB    = 2'h2;
    localparam logic [1:0] MAP_CH2_SUB    = 2'h3;
    localparam logic [2:0] BASS_OFF       = 3'h0;
    localparam int         SYNC_STAGES    = 2;
    localparam logic       MIX_OVERRIDE_RESET = 1'b0;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic       pinFunctionSelect;
        logic       pinActiveLevel;
        logic [1:0] logicOutputMapSelect;
        logic       logicOutputDriveEnable;
        logic [2:0] subCrossoverSelect;
        logic [1:0] leftMixerSelect;
        logic [1:0] rightMixerSelect;
        logic       twoWayCrossoverEnable;
    } hmr_cfg_t;

    typedef struct packed {
        logic [1:0] leftMixerSelect;
        logic [1:0] rightMixerSelect;
        logic       twoWayCrossoverEnable;
        logic [2:0] subCrossoverSelect;
    } hmr_dsp_t;

    // Per logic-level output: source selection
    typedef enum {
        HMR_SRC_LOW,
        HMR_SRC_CH1,
        HMR_SRC_CH2,
        HMR_SRC_SUB,
        HMR_SRC_MUTE
    } hmr_src_t;

endpackage : hmr_pkg
